// ---- src/tsp_pkg.sv ----
// Constants, register map and carrier types of the thermal sensor poller.
// What this block does
// - Interval zero disables; else 250 ms steps.
// - Completed poll stores received byte as latest.
// - Reading at or above threshold cuts power.
// - Command byte addresses sensor register each poll.
// - Eight-bit retry limit, reset value 0x10.
// - Software-written latest value reads back until update.
// - Seven-bit slave address; zero disables polling.
// - Reading at or above high alarm flags event.
// - Reading at or below low alarm flags event.
package tsp_pkg;

   // Clock and timing.
   localparam int unsigned CLK_HZ             = 10_000_000;
   localparam int unsigned POLL_STEP_MS       = 250;
   localparam int unsigned POLL_STEP_CYCLES   = (CLK_HZ / 1000) * POLL_STEP_MS;
   localparam int unsigned SCL_HZ             = 100_000;
   localparam int unsigned SCL_QUARTER_CYCLES = CLK_HZ / (4 * SCL_HZ);

   // Register offsets.
   localparam logic [7:0] OFS_SLAVE_ADDR  = 8'he3;
   localparam logic [7:0] OFS_HIGH_ALARM  = 8'he4;
   localparam logic [7:0] OFS_LOW_ALARM   = 8'he5;
   localparam logic [7:0] OFS_POLL_PERIOD = 8'he6;
   localparam logic [7:0] OFS_LATEST      = 8'he7;
   localparam logic [7:0] OFS_OFF_LEVEL   = 8'he8;
   localparam logic [7:0] OFS_COMMAND     = 8'he9;
   localparam logic [7:0] OFS_RETRY       = 8'hea;
   localparam logic [7:0] OFS_BURST_CLR   = 8'hf0;
   localparam logic [7:0] OFS_IRQ_STATUS  = 8'hf1;
   localparam logic [7:0] OFS_IRQ_MASK    = 8'hf2;
   localparam logic [7:0] OFS_POLL_STATE  = 8'hf3;
   localparam logic [7:0] BURST_RANGE_LO  = 8'ha8;
   localparam logic [7:0] BURST_RANGE_HI  = 8'haf;
   localparam logic [7:0] BURST_CLR_CODE  = 8'h00;

   // Reset values.
   localparam logic [7:0] RST_OFF_LEVEL = 8'h7d;
   localparam logic [7:0] RST_RETRY     = 8'h10;
   localparam logic [7:0] RST_ZERO      = 8'h00;

   // Interrupt status bit positions.
   localparam int unsigned IRQ_W       = 4;
   localparam int unsigned IRQ_HIGH    = 0;
   localparam int unsigned IRQ_LOW     = 1;
   localparam int unsigned IRQ_FAIL    = 2;
   localparam int unsigned IRQ_POWEROFF = 3;

   // Sensor bus direction bits.
   localparam logic DIR_WRITE = 1'b0;
   localparam logic DIR_READ  = 1'b1;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } tsp_bus_req_t;

   typedef enum logic [2:0] {
      ST_IDLE, ST_START, ST_TXB, ST_RXACK, ST_RXB, ST_TXNACK, ST_STOP
   } tsp_state_t;

endpackage : tsp_pkg

// ---- src/tsp_poller.sv ----
// Thermal sensor poller: register port, poll timer and sensor bus read engine.
//
// Strobed register access was decided locally.
`timescale 1ns/100ps
module tsp_poller import tsp_pkg::*; #(
   parameter int unsigned STEP_CYCLES    = POLL_STEP_CYCLES,
   parameter int unsigned QUARTER_CYCLES = SCL_QUARTER_CYCLES
) (
   // Clock and reset.
   input  wire logic         mclk,
   input  wire logic         sys_rst,
   // Register port.
   input  wire tsp_bus_req_t bus_req,
   output logic [7:0]        rd_data,
   // Sensor bus pins, open drain.
   input  wire logic         scl_in,
   output logic              scl_out,
   output logic              scl_oe,
   input  wire logic         sda_in,
   output logic              sda_out,
   output logic              sda_oe,
   // System outputs.
   output logic              irq,
   output logic              power_off
);

   localparam int SW = $clog2(STEP_CYCLES + 1);
   localparam int QW = $clog2(QUARTER_CYCLES + 1);

   if (STEP_CYCLES < 2 || QUARTER_CYCLES < 2) begin : g_check
      $error("tsp_poller: STEP_CYCLES and QUARTER_CYCLES must be at least 2");
   end

   function automatic logic greater_or_equal_compare(input logic [7:0] a, input logic [7:0] b);
      greater_or_equal_compare = $signed(a) >= $signed(b);
   endfunction : greater_or_equal_compare

   function automatic logic less_or_equal_compare(input logic [7:0] a, input logic [7:0] b);
      less_or_equal_compare = $signed(a) <= $signed(b);
   endfunction : less_or_equal_compare

   // Pin synchronisers.
   logic [1:0] scl_sync;
   logic [1:0] sda_sync;

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         scl_sync <= 2'h3;
         sda_sync <= 2'h3;
      end else begin
         scl_sync <= {scl_sync[0], scl_in};
         sda_sync <= {sda_sync[0], sda_in};
      end
   end

   // Register state.
   logic [6:0]       slave_addr,     next_slave_addr;
   logic [7:0]       high_alarm,     next_high_alarm;
   logic [7:0]       low_alarm,      next_low_alarm;
   logic [7:0]       poll_period,    next_poll_period;
   logic [7:0]       latest,         next_latest;
   logic [7:0]       off_level,      next_off_level;
   logic [7:0]       command,        next_command;
   logic [7:0]       retry_limit,    next_retry_limit;
   logic [7:0]       burst_clear,    next_burst_clear;
   logic [IRQ_W-1:0] irq_status,     next_irq_status;
   logic [IRQ_W-1:0] irq_mask,       next_irq_mask;
   logic             burst_pending,  next_burst_pending;
   logic [7:0]       next_rd_data;
   logic             next_irq;
   logic             next_power_off;

   // Engine state.
   tsp_state_t       state,          next_state;
   logic [1:0]       ph,             next_ph;
   logic [QW-1:0]    qcnt,           next_qcnt;
   logic [SW-1:0]    step_cnt,       next_step_cnt;
   logic [7:0]       interval_cnt,   next_interval_cnt;
   logic             poll_due,       next_poll_due;
   logic [2:0]       bitn,           next_bitn;
   logic [1:0]       byte_sel,       next_byte_sel;
   logic [7:0]       shreg,          next_shreg;
   logic [7:0]       tries,          next_tries;
   logic             nacked,         next_nacked;
   logic             scl_low,        next_scl_low;
   logic             sda_low,        next_sda_low;
   logic             ev_ok,          next_ev_ok;
   logic             ev_fail,        next_ev_fail;
   logic [7:0]       rx_data,        next_rx_data;

   logic             wr;
   logic             rd;
   logic [7:0]       addr;
   logic             poll_en;
   logic             qtick;
   logic             stall;
   logic [IRQ_W-1:0] irq_set;

   assign wr      = bus_req.wr;
   assign rd      = bus_req.rd;
   assign addr    = bus_req.addr;
   assign poll_en = (poll_period != RST_ZERO) && (slave_addr != 7'h00);

   // Register file, events and interrupt.
   always_comb begin
      next_slave_addr    = slave_addr;
      next_high_alarm    = high_alarm;
      next_low_alarm     = low_alarm;
      next_poll_period   = poll_period;
      next_latest        = latest;
      next_off_level     = off_level;
      next_command       = command;
      next_retry_limit   = retry_limit;
      next_burst_clear   = burst_clear;
      next_irq_mask      = irq_mask;
      next_burst_pending = burst_pending;
      next_rd_data       = RST_ZERO;
      irq_set            = '0;
      if (wr) begin
         unique case (addr)
            OFS_SLAVE_ADDR:  next_slave_addr  = bus_req.wdata[6:0];
            OFS_HIGH_ALARM:  next_high_alarm  = bus_req.wdata;
            OFS_LOW_ALARM:   next_low_alarm   = bus_req.wdata;
            OFS_POLL_PERIOD: next_poll_period = bus_req.wdata;
            OFS_LATEST:      next_latest      = bus_req.wdata;
            OFS_OFF_LEVEL:   next_off_level   = bus_req.wdata;
            OFS_COMMAND:     next_command     = bus_req.wdata;
            OFS_RETRY:       next_retry_limit = bus_req.wdata;
            OFS_BURST_CLR: begin
               next_burst_clear = bus_req.wdata;
               if (bus_req.wdata == BURST_CLR_CODE) begin
                  next_burst_pending = 1'b0;
               end
            end
            OFS_IRQ_MASK:    next_irq_mask    = bus_req.wdata[IRQ_W-1:0];
            default: begin
               if (addr >= BURST_RANGE_LO && addr <= BURST_RANGE_HI) begin
                  next_burst_pending = 1'b1;
               end
            end
         endcase
      end
      if (rd) begin
         unique case (addr)
            OFS_SLAVE_ADDR:  next_rd_data = {1'b0, slave_addr};
            OFS_HIGH_ALARM:  next_rd_data = high_alarm;
            OFS_LOW_ALARM:   next_rd_data = low_alarm;
            OFS_POLL_PERIOD: next_rd_data = poll_period;
            OFS_LATEST:      next_rd_data = latest;
            OFS_OFF_LEVEL:   next_rd_data = off_level;
            OFS_COMMAND:     next_rd_data = command;
            OFS_RETRY:       next_rd_data = retry_limit;
            OFS_BURST_CLR:   next_rd_data = burst_clear;
            OFS_IRQ_STATUS:  next_rd_data = {{(8-IRQ_W){1'b0}}, irq_status};
            OFS_IRQ_MASK:    next_rd_data = {{(8-IRQ_W){1'b0}}, irq_mask};
            OFS_POLL_STATE:  next_rd_data = {6'h00, burst_pending, state != ST_IDLE};
            default:         next_rd_data = RST_ZERO;
         endcase
      end
      if (ev_ok) begin
         next_latest            = rx_data;
         irq_set[IRQ_HIGH]      = greater_or_equal_compare(rx_data, high_alarm);
         irq_set[IRQ_LOW]       = less_or_equal_compare(rx_data, low_alarm);
         irq_set[IRQ_POWEROFF]  = greater_or_equal_compare(rx_data, off_level);
      end
      irq_set[IRQ_FAIL] = ev_fail;
      // A read clears the status, but an event in the same cycle survives.
      next_irq_status = ((rd && addr == OFS_IRQ_STATUS) ? '0 : irq_status) | irq_set;
      next_irq        = |(next_irq_status & next_irq_mask);
      next_power_off  = power_off | irq_set[IRQ_POWEROFF];
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         slave_addr    <= 7'h00;
         high_alarm    <= RST_ZERO;
         low_alarm     <= RST_ZERO;
         poll_period   <= RST_ZERO;
         latest        <= RST_ZERO;
         off_level     <= RST_OFF_LEVEL;
         command       <= RST_ZERO;
         retry_limit   <= RST_RETRY;
         burst_clear   <= RST_ZERO;
         irq_status    <= '0;
         irq_mask      <= '0;
         burst_pending <= 1'b0;
         rd_data       <= RST_ZERO;
         irq           <= 1'b0;
         power_off     <= 1'b0;
      end else begin
         slave_addr    <= next_slave_addr;
         high_alarm    <= next_high_alarm;
         low_alarm     <= next_low_alarm;
         poll_period   <= next_poll_period;
         latest        <= next_latest;
         off_level     <= next_off_level;
         command       <= next_command;
         retry_limit   <= next_retry_limit;
         burst_clear   <= next_burst_clear;
         irq_status    <= next_irq_status;
         irq_mask      <= next_irq_mask;
         burst_pending <= next_burst_pending;
         rd_data       <= next_rd_data;
         irq           <= next_irq;
         power_off     <= next_power_off;
      end
   end

   // Each bit takes four quarter periods; the high phase waits while the sensor stretches SCL.
   assign qtick = (qcnt == QW'(QUARTER_CYCLES - 1));
   assign stall = (ph == 2'd2) && !scl_low && !scl_sync[1];

   // Poll timer and sensor bus engine.
   always_comb begin
      next_state        = state;
      next_ph           = ph;
      next_qcnt         = qcnt;
      next_step_cnt     = step_cnt;
      next_interval_cnt = interval_cnt;
      next_poll_due     = poll_due;
      next_bitn         = bitn;
      next_byte_sel     = byte_sel;
      next_shreg        = shreg;
      next_tries        = tries;
      next_nacked       = nacked;
      next_scl_low      = scl_low;
      next_sda_low      = sda_low;
      next_ev_ok        = 1'b0;
      next_ev_fail      = 1'b0;
      next_rx_data      = rx_data;
      if (!poll_en) begin
         next_step_cnt     = '0;
         next_interval_cnt = RST_ZERO;
         next_poll_due     = 1'b0;
      end else if (step_cnt == SW'(STEP_CYCLES - 1)) begin
         next_step_cnt = '0;
         if (interval_cnt == poll_period - 8'h01) begin
            next_interval_cnt = RST_ZERO;
            next_poll_due     = 1'b1;
         end else begin
            next_interval_cnt = interval_cnt + 8'h01;
         end
      end else begin
         next_step_cnt = step_cnt + SW'(1);
      end
      if (state == ST_IDLE) begin
         next_qcnt = '0;
         next_ph   = 2'd0;
         if (poll_due) begin
            next_poll_due = 1'b0;
            next_state    = ST_START;
            next_byte_sel = 2'd0;
            next_tries    = RST_ZERO;
         end
      end else if (!qtick) begin
         next_qcnt = qcnt + QW'(1);
      end else if (!stall) begin
         next_qcnt = '0;
         next_ph   = ph + 2'd1;
         unique case (state)
            ST_START: begin
               unique case (ph)
                  2'd0: next_sda_low = 1'b0;
                  2'd1: next_scl_low = 1'b0;
                  2'd2: next_sda_low = 1'b1;
                  2'd3: begin
                     next_scl_low = 1'b1;
                     next_shreg   = {slave_addr, (byte_sel == 2'd2) ? DIR_READ : DIR_WRITE};
                     next_bitn    = 3'd0;
                     next_state   = ST_TXB;
                  end
               endcase
            end
            ST_TXB, ST_TXNACK: begin
               unique case (ph)
                  2'd0: next_sda_low = (state == ST_TXB) && !shreg[7];
                  2'd1: next_scl_low = 1'b0;
                  2'd2: next_scl_low = 1'b0;
                  2'd3: begin
                     next_scl_low = 1'b1;
                     next_shreg   = (state == ST_TXB) ? {shreg[6:0], 1'b0} : shreg;
                     next_bitn    = bitn + 3'd1;
                     if (state == ST_TXNACK) begin
                        next_nacked = 1'b0;
                        next_state  = ST_STOP;
                     end else if (bitn == 3'd7) begin
                        next_state = ST_RXACK;
                     end
                  end
               endcase
            end
            ST_RXACK, ST_RXB: begin
               unique case (ph)
                  2'd0: next_sda_low = 1'b0;
                  2'd1: next_scl_low = 1'b0;
                  2'd2: begin
                     if (state == ST_RXACK) begin
                        next_nacked = sda_sync[1];
                     end else begin
                        next_shreg = {shreg[6:0], sda_sync[1]};
                     end
                  end
                  2'd3: begin
                     next_scl_low = 1'b1;
                     if (state == ST_RXB) begin
                        next_bitn = bitn + 3'd1;
                        if (bitn == 3'd7) begin
                           next_state = ST_TXNACK;
                        end
                     end else if (nacked) begin
                        next_state = ST_STOP;
                     end else if (byte_sel == 2'd0) begin
                        next_byte_sel = 2'd1;
                        next_shreg    = command;
                        next_bitn     = 3'd0;
                        next_state    = ST_TXB;
                     end else if (byte_sel == 2'd1) begin
                        next_byte_sel = 2'd2;
                        next_state    = ST_START;
                     end else begin
                        next_bitn  = 3'd0;
                        next_state = ST_RXB;
                     end
                  end
               endcase
            end
            ST_STOP: begin
               unique case (ph)
                  2'd0: next_sda_low = 1'b1;
                  2'd1: next_scl_low = 1'b0;
                  2'd2: next_sda_low = 1'b0;
                  2'd3: begin
                     if (!nacked) begin
                        next_ev_ok   = 1'b1;
                        next_rx_data = shreg;
                        next_state   = ST_IDLE;
                     end else if (tries < retry_limit) begin
                        next_tries    = tries + 8'h01;
                        next_byte_sel = 2'd0;
                        next_state    = ST_START;
                     end else begin
                        next_ev_fail = 1'b1;
                        next_state   = ST_IDLE;
                     end
                  end
               endcase
            end
            default: next_state = ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         state        <= ST_IDLE;
         ph           <= 2'd0;
         qcnt         <= '0;
         step_cnt     <= '0;
         interval_cnt <= RST_ZERO;
         poll_due     <= 1'b0;
         bitn         <= 3'd0;
         byte_sel     <= 2'd0;
         shreg        <= RST_ZERO;
         tries        <= RST_ZERO;
         nacked       <= 1'b0;
         scl_low      <= 1'b0;
         sda_low      <= 1'b0;
         ev_ok        <= 1'b0;
         ev_fail      <= 1'b0;
         rx_data      <= RST_ZERO;
         scl_out      <= 1'b0;
         scl_oe       <= 1'b0;
         sda_out      <= 1'b0;
         sda_oe       <= 1'b0;
      end else begin
         state        <= next_state;
         ph           <= next_ph;
         qcnt         <= next_qcnt;
         step_cnt     <= next_step_cnt;
         interval_cnt <= next_interval_cnt;
         poll_due     <= next_poll_due;
         bitn         <= next_bitn;
         byte_sel     <= next_byte_sel;
         shreg        <= next_shreg;
         tries        <= next_tries;
         nacked       <= next_nacked;
         scl_low      <= next_scl_low;
         sda_low      <= next_sda_low;
         ev_ok        <= next_ev_ok;
         ev_fail      <= next_ev_fail;
         rx_data      <= next_rx_data;
         scl_out      <= 1'b0;
         scl_oe       <= next_scl_low;
         sda_out      <= 1'b0;
         sda_oe       <= next_sda_low;
      end
   end

endmodule : tsp_poller

// ---- test/tsp_poller_assertions.sv ----
// Port-level checker for the thermal sensor poller.
`timescale 1ns/100ps
module tsp_checker import tsp_pkg::*; #(
   parameter int unsigned QUARTER_CYCLES = SCL_QUARTER_CYCLES
) (
   // Clock and reset.
   input wire logic         mclk,
   input wire logic         sys_rst,
   // Register port.
   input wire tsp_bus_req_t bus_req,
   input wire logic [7:0]   rd_data,
   // Sensor bus pins and system outputs.
   input wire logic         scl_in,
   input wire logic         scl_out,
   input wire logic         scl_oe,
   input wire logic         sda_in,
   input wire logic         sda_out,
   input wire logic         sda_oe,
   input wire logic         irq,
   input wire logic         power_off
);
   logic [7:0]  per_q, slv_q, cmd_q, ret_q, off_q;
   logic        idle, sda_oe_q;
   logic [15:0] since_stop;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   // Data moving while the clock is released marks start or stop.
   wire         start_evt = !sda_oe_q && sda_oe && !scl_oe;
   wire         stop_evt  = sda_oe_q && !sda_oe && !scl_oe;

   always_ff @(posedge mclk) begin
      sda_oe_q <= sda_oe;
      if (sys_rst) begin
         per_q      <= RST_ZERO;
         slv_q      <= RST_ZERO;
         cmd_q      <= RST_ZERO;
         ret_q      <= RST_RETRY;
         off_q      <= RST_OFF_LEVEL;
         idle       <= 1'b1;
         since_stop <= 16'hffff;
      end else begin
         if (bus_req.wr && bus_req.addr == OFS_POLL_PERIOD) per_q <= bus_req.wdata;
         if (bus_req.wr && bus_req.addr == OFS_SLAVE_ADDR) slv_q <= {1'b0, bus_req.wdata[6:0]};
         if (bus_req.wr && bus_req.addr == OFS_COMMAND) cmd_q <= bus_req.wdata;
         if (bus_req.wr && bus_req.addr == OFS_RETRY) ret_q <= bus_req.wdata;
         if (bus_req.wr && bus_req.addr == OFS_OFF_LEVEL) off_q <= bus_req.wdata;
         if (start_evt) idle <= 1'b0;
         else if (stop_evt) idle <= 1'b1;
         if (stop_evt) since_stop <= 16'h0000;
         else if (since_stop != 16'hffff) since_stop <= since_stop + 16'h0001;
      end
   end

   a_period_readback: assert property (
      bus_req.rd && bus_req.addr == OFS_POLL_PERIOD |=> rd_data == per_q)
      else $error("poll period read back wrong");
   a_retry_readback: assert property (
      bus_req.rd && bus_req.addr == OFS_RETRY |=> rd_data == ret_q)
      else $error("retry limit read back wrong");
   a_level_readback: assert property (
      bus_req.rd && bus_req.addr == OFS_OFF_LEVEL |=> rd_data == off_q)
      else $error("power-off level read back wrong");
   a_command_readback: assert property (
      bus_req.rd && bus_req.addr == OFS_COMMAND |=> rd_data == cmd_q)
      else $error("command byte read back wrong");
   a_latest_readback: assert property (
      bus_req.wr && bus_req.addr == OFS_LATEST ##2 bus_req.rd && bus_req.addr == OFS_LATEST
      |=> rd_data == $past(bus_req.wdata, 3))
      else $error("written reading not returned");
   a_rdata_idle: assert property (
      !bus_req.rd |=> rd_data == 8'h00)
      else $error("read data outside read slot");
   a_poll_enabled: assert property (
      start_evt && idle |-> per_q != RST_ZERO && slv_q != RST_ZERO)
      else $error("poll started while disabled");
   a_power_sticky: assert property (
      power_off |=> power_off)
      else $error("power-off output dropped");
   a_power_after_stop: assert property (
      $rose(power_off) |-> since_stop <= 16'(4 * QUARTER_CYCLES + 4))
      else $error("power-off not tied to a finished poll");
   a_pins_low: assert property (!scl_out && !sda_out)
      else $error("sensor pin driven high");
endmodule : tsp_checker

bind tsp_poller tsp_checker #(.QUARTER_CYCLES(QUARTER_CYCLES)) chk_u (
   .mclk(mclk), .sys_rst(sys_rst), .bus_req(bus_req), .rd_data(rd_data),
   .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in),
   .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq), .power_off(power_off));

// ---- test/tsp_sensor_model.sv ----
// Behavioural temperature sensor answering byte reads on the two-wire bus.
`timescale 1ns/100ps
module tsp_sensor_model #(
   parameter logic [6:0] DEV_ADDR = 7'h4c
) (
   // Clock and wire levels.
   input  wire logic       mclk,
   input  wire logic       scl,
   input  wire logic       sda,
   // Behaviour controls.
   input  wire logic [7:0] temp,
   input  wire logic       refuse,
   input  wire logic       slow,
   // Line pull-downs and observations.
   output logic            scl_oe,
   output logic            sda_oe,
   output logic [7:0]      cmd_seen,
   output logic [7:0]      starts
);
   logic       scl_q, sda_q, first, tx;
   logic [3:0] cnt;
   logic [7:0] sh;
   logic [2:0] hold;

   initial begin
      {scl_oe, sda_oe, first, tx, cnt, sh, hold, cmd_seen, starts} = '0;
      {scl_q, sda_q} = 2'b11;
   end

   // Data changes only after a falling clock.
   always @(posedge mclk) begin
      scl_q <= scl;
      sda_q <= sda;
      hold <= (slow && scl_q && !scl) ? 3'd5 : (hold != 3'd0 ? hold - 3'd1 : 3'd0);
      scl_oe <= (slow && scl_q && !scl) || hold > 3'd1;
      if (scl_q && scl && sda_q && !sda) begin
         starts <= starts + 8'h01;
         {cnt, tx, first, sda_oe} <= {4'hf, 1'b0, 1'b1, 1'b0};
      end else if (!scl_q && scl && !tx && cnt < 4'd8) begin
         sh <= {sh[6:0], sda};
      end else if (scl_q && !scl) begin
         if (cnt == 4'd7) begin
            cnt <= 4'd8;
            sda_oe <= !tx && !refuse && (!first || sh[7:1] == DEV_ADDR);
            if (!first && !tx) cmd_seen <= sh;
         end else if (cnt == 4'd8) begin
            cnt <= 4'd0;
            first <= 1'b0;
            tx <= !tx && first && sh[0] && sda_oe;
            sda_oe <= !tx && first && sh[0] && sda_oe && !temp[7];
         end else begin
            cnt <= cnt + 4'd1;
            sda_oe <= tx && !temp[3'd6 - cnt[2:0]];
         end
      end
   end
endmodule : tsp_sensor_model

// ---- test/thermal_sensor_poller_tb_top.sv ----
// Self-checking bench for the thermal sensor poller with a sensor model.
`timescale 1ns/100ps
module thermal_sensor_poller_tb_top import tsp_pkg::*;;
   logic         mclk, sys_rst, scl_out, scl_oe, sda_out, sda_oe, irq, power_off;
   logic         m_scl_oe, m_sda_oe, refuse, slow;
   tsp_bus_req_t bus_req;
   logic [7:0]   rd_data, temp, cmd_seen, starts, n0;
   wire          scl = !(scl_oe || m_scl_oe);
   wire          sda = !(sda_oe || m_sda_oe);
   int           fails = 0, compares = 0, cycles = 0;

   tsp_poller #(.STEP_CYCLES(20), .QUARTER_CYCLES(2)) dut_u (
      .mclk(mclk), .sys_rst(sys_rst), .bus_req(bus_req), .rd_data(rd_data), .scl_in(scl),
      .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
      .irq(irq), .power_off(power_off));
   tsp_sensor_model #(.DEV_ADDR(7'h4c)) sensor_u (
      .mclk(mclk), .scl(scl), .sda(sda), .temp(temp), .refuse(refuse), .slow(slow),
      .scl_oe(m_scl_oe), .sda_oe(m_sda_oe), .cmd_seen(cmd_seen), .starts(starts));

   always #50 mclk = !mclk;

   always @(posedge mclk) begin
      cycles++;
      if (cycles == 60000) begin
         fails++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : print_verdict

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk) bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge mclk) bus_req <= '0;
   endtask : wr

   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge mclk) bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge mclk) bus_req <= '0;
      @(negedge mclk) chk(rd_data, exp);
   endtask : rchk

   // Runs one poll and checks the status bits that it set.
   task automatic poll(input logic [7:0] t, input logic [7:0] exp);
      int n;
      temp <= t;
      wr(OFS_POLL_PERIOD, 8'hff);
      for (n = 0; irq !== 1'b1 && n < 8000; n++) @(posedge mclk);
      wr(OFS_POLL_PERIOD, 8'h00);
      repeat (600) @(posedge mclk);
      rchk(OFS_IRQ_STATUS, exp);
   endtask : poll

   task automatic t_registers();
      logic [7:0] ofs [5] = '{OFS_POLL_PERIOD, OFS_LATEST, OFS_OFF_LEVEL, OFS_COMMAND, OFS_RETRY};
      logic [7:0] rst [5] = '{8'h00, 8'h00, 8'h7d, 8'h00, 8'h10};
      for (int i = 0; i < 5; i++) rchk(ofs[i], rst[i]);
      for (int i = 0; i < 5; i++) begin
         wr(ofs[i], 8'ha5 ^ 8'(i));
         rchk(ofs[i], 8'ha5 ^ 8'(i));
      end
      rchk(8'heb, 8'h00);
      wr(8'ha8, 8'h33);
      rchk(OFS_POLL_STATE, 8'h02);
      wr(OFS_BURST_CLR, BURST_CLR_CODE);
      rchk(OFS_POLL_STATE, 8'h00);
      wr(OFS_POLL_PERIOD, 8'h00);
      wr(OFS_SLAVE_ADDR, 8'h4c);
      wr(OFS_COMMAND, 8'h3c);
      wr(OFS_HIGH_ALARM, 8'h19);
      wr(OFS_LOW_ALARM, 8'h80);
      wr(OFS_OFF_LEVEL, RST_OFF_LEVEL);
      wr(OFS_RETRY, 8'h00);
      wr(OFS_IRQ_MASK, 8'h0f);
   endtask : t_registers

   task automatic t_poll_high();
      n0 = starts;
      poll(8'h19, 8'h01);
      chk(starts - n0, 8'h02);
      rchk(OFS_LATEST, 8'h19);
      chk(cmd_seen, 8'h3c);
      chk({7'h00, irq}, 8'h00);
      chk({7'h00, power_off}, 8'h00);
   endtask : t_poll_high

   task automatic t_poll_low_slow();
      wr(OFS_LOW_ALARM, 8'hf6);
      slow <= 1'b1;
      poll(8'hf6, 8'h02);
      slow <= 1'b0;
      rchk(OFS_LATEST, 8'hf6);
   endtask : t_poll_low_slow

   task automatic t_retry();
      wr(OFS_RETRY, 8'h02);
      refuse <= 1'b1;
      n0 = starts;
      poll(8'h33, 8'h04);
      refuse <= 1'b0;
      chk(starts - n0, 8'h03);
      rchk(OFS_LATEST, 8'hf6);
   endtask : t_retry

   task automatic t_disabled();
      wr(OFS_SLAVE_ADDR, 8'h00);
      wr(OFS_POLL_PERIOD, 8'hff);
      n0 = starts;
      repeat (5500) @(posedge mclk);
      chk(starts - n0, 8'h00);
      wr(OFS_POLL_PERIOD, 8'h00);
      wr(OFS_SLAVE_ADDR, 8'h4c);
      repeat (5500) @(posedge mclk);
      chk(starts - n0, 8'h00);
   endtask : t_disabled

   task automatic t_shutdown();
      poll(8'h7c, 8'h01);
      chk({7'h00, power_off}, 8'h00);
      poll(8'h7d, 8'h09);
      chk({7'h00, power_off}, 8'h01);
   endtask : t_shutdown

   initial begin
      mclk = 1'b0;
      sys_rst = 1'b1;
      bus_req = '0;
      temp = 8'h00;
      refuse = 1'b0;
      slow = 1'b0;
      repeat (10) @(posedge mclk);
      sys_rst <= 1'b0;
      t_registers();
      t_poll_high();
      t_poll_low_slow();
      t_retry();
      t_disabled();
      t_shutdown();
      print_verdict();
   end
endmodule : thermal_sensor_poller_tb_top
